// ==== common/sfs_consts.svh ====
// Purpose: Constants for the flash status register bank
// Assumes: Opcodes arrive MSB first on the serial data input
// Notes:   Positions not fixed by the pin-level framing are local choices
// Contract
// [RULE1] Busy flag is 1 while program, erase, status write or security op runs.
// [RULE2] While busy, only status reads and suspend are taken; all else dropped.
// [RULE3] Write enable 06h sets the write-enable latch; no direct write to it.
// [RULE4] Latch clears on power-up, 04h, program, erase, status or security writes.
// [RULE5] Three block-protect bits are writable, default 0 protects nothing.
// [RULE6] Top/bottom bit 0 protects from top, 1 from bottom.
// [RULE7] Host always writes sector/block protect bit as 0.
// [RULE8] Protect bits 0,0: status write allowed whenever latch is set.
// [RULE9] Protect bits 0,1: write refused while protect pin low, allowed when high.
// [RULE10] Protect bits 1,0: writes refused until power cycle, which returns 0,0.
// [RULE11] Protect bits 1,1: status writes refused permanently. The code clears both bits at power-on reset.
// [RULE12] Shared pin is hold when select is 0, reset when 1, only if quad is 0.
// [RULE13] Complement bit inverts the protected region.
// [RULE14] Scheme bit picks protect fields or lock bits; locks read 1 after reset.
// [RULE15] Drive bits 00,10,01,11 give 100, 75, 50, 25 percent.
// [RULE16] Security lock bit is one-time; once 1 the security area is read-only. The code clears it at power-on reset.
// [RULE17] Quad enable 1 turns protect and hold pins into data lines.
// [RULE18] Enter-QPI 38h ignored unless quad is 1; quad stays 1 in QPI.
// [RULE19] A status write in QPI cannot clear quad enable.
// [RULE20] Write enable 06h clears the write-fail flag.
// [RULE21] Opcodes 05h, 35h, 15h read status one, two and three.
// [RULE22] 01h writes status one (and two), 31h writes two, 50h volatile enable.
// [RULE23] Write-fail sets on a failed operation; clears on 06h or reset.
// [RULE24] Suspend flag sets on 75h, clears on 7Ah or power cycle.
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH
`define SFS_OP_RD1      8'h05
`define SFS_OP_RD2      8'h35
`define SFS_OP_RD3      8'h15
`define SFS_OP_WR1      8'h01
`define SFS_OP_WR2      8'h31
`define SFS_OP_WEN      8'h06
`define SFS_OP_WDIS     8'h04
`define SFS_OP_VWEN     8'h50
`define SFS_OP_QPI_ON   8'h38
`define SFS_OP_QPI_OFF  8'hff
`define SFS_OP_SUSP     8'h75
`define SFS_OP_RESUME   8'h7a
`define SFS_OP_RST_ARM  8'h66
`define SFS_OP_RST_GO   8'h99
`define SFS_OP_PP       8'h02
`define SFS_OP_QPP      8'h32
`define SFS_OP_SE       8'h20
`define SFS_OP_BE32     8'h52
`define SFS_OP_BE64     8'hd8
`define SFS_OP_CE       8'hc7
`define SFS_OP_CE2      8'h60
`define SFS_OP_SSE      8'h44
`define SFS_OP_SSP      8'h42
`define SFS_ST3_ERR     2
`define SFS_ST3_SUSP    7
`define SFS_PIN_RESET   5'h0b
`define SFS_TW_NS       5000
`define SFS_CLK_NS      10
`define SFS_TW_CYC      ((`SFS_TW_NS) / (`SFS_CLK_NS))
`endif

// ==== common/sfs_pkg.sv ====
// Purpose: Types for the flash status register bank
// Assumes: Nothing
// Notes:   Constants live in sfs_consts.svh
package sfs_pkg;
	typedef logic [7:0] sfs_op_t;
	typedef enum logic [1:0] {SFS_DRV_100, SFS_DRV_50, SFS_DRV_75, SFS_DRV_25} sfs_drv_e;
endpackage

// ==== logic/sfs_status_bank.sv ====
// Purpose: Status register bank behind the serial flash pins
// Assumes: Serial clock well below clock_in/4; engine signals on clock_in
// Notes:   Non-volatile bits take factory values at power-on reset
`timescale 1ns/100ps
`include "sfs_consts.svh"
module sfs_status_bank import sfs_pkg::*; #(
	parameter int TW_CYC = `SFS_TW_CYC
) (
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	input  wire logic       sclk_in,
	input  wire logic       cs_n_in,
	input  wire logic       si_in,
	input  wire logic       wp_n_in,
	input  wire logic       hold_rst_n_in,
	input  wire logic       eng_busy_in,
	input  wire logic       eng_fail_in,
	output logic            so_out,
	output logic            so_oe_out,
	output logic            cmd_valid_out,
	output logic [7:0]      cmd_op_out,
	output logic            busy_out,
	output logic            qpi_mode_out,
	output logic            hold_out,
	output logic            pin_reset_out,
	output logic [6:0]      drive_pct_out,
	output logic [2:0]      prot_bits_out,
	output logic            prot_bottom_out,
	output logic            prot_sector_out,
	output logic            prot_invert_out,
	output logic            prot_locks_out,
	output logic            lock_preset_out,
	output logic            secure_ro_out
);
	// Busy check below expects at least eight busy cycles per non-volatile status write
	if (TW_CYC < 8 || TW_CYC > 65535) begin : g_tw_check
		$error("TW_CYC out of range");
	end

	// ==========================================================
	// Reset release and pin synchronisers
	logic [1:0] rs_q;
	logic       por_n;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) rs_q <= 2'h0;
		else rs_q <= {rs_q[0], 1'b1};
	end
	assign por_n = rs_q[1];

	logic [4:0] p1_q, p2_q;
	logic       sclk_prev_q, cs_prev_q;
	always_ff @(posedge clock_in or negedge por_n) begin
		if (!por_n) begin
			p1_q        <= `SFS_PIN_RESET;
			p2_q        <= `SFS_PIN_RESET;
			sclk_prev_q <= 1'b0;
			cs_prev_q   <= 1'b1;
		end else begin
			p1_q        <= {sclk_in, cs_n_in, si_in, wp_n_in, hold_rst_n_in};
			p2_q        <= p1_q;
			sclk_prev_q <= p2_q[4];
			cs_prev_q   <= p2_q[3];
		end
	end
	logic sclk_s, cs_n_s, si_s, wp_n_s, hr_n_s, rise, fall, cs_end;
	assign {sclk_s, cs_n_s, si_s, wp_n_s, hr_n_s} = p2_q;
	assign rise   = sclk_s & ~sclk_prev_q;
	assign fall   = ~sclk_s & sclk_prev_q;
	assign cs_end = cs_n_s & ~cs_prev_q;

	// ==========================================================
	// Status bits
	logic       write_enable_latch_q, vol_en_q, busy_run;
	logic [2:0] prot_q;
	logic       bottom_q, sector_q, sp_low_q, sp_high_q, quad_enable_q, otp_lock_q;
	logic       pin_mode_q, drv_low_q, drv_high_q, invert_q, scheme_q;
	logic       err_q, susp_q, qpi_q, arm_q, soft_rst_q, sw_rst;
	logic [15:0] tw_q;
	logic [7:0] stat1, stat2, stat3;
	assign busy_run = eng_busy_in | (tw_q != 16'h0);
	assign busy_out = busy_run; // [RULE1]
	assign stat1 = {sp_low_q, sector_q, bottom_q, prot_q, write_enable_latch_q, busy_run};
	assign stat2 = {scheme_q, invert_q, drv_high_q, drv_low_q, pin_mode_q, otp_lock_q,
		quad_enable_q, sp_high_q};
	always_comb begin
		stat3 = 8'h00;
		stat3[`SFS_ST3_ERR]  = err_q;
		stat3[`SFS_ST3_SUSP] = susp_q;
	end

	// Shared pin acts only while quad mode leaves it a control pin
	assign pin_reset_out = ~quad_enable_q & pin_mode_q & ~hr_n_s; // [RULE12] [RULE17]
	assign hold_out = ~quad_enable_q & ~pin_mode_q & ~hr_n_s & ~cs_n_s; // [RULE12] [RULE17]
	assign sw_rst = pin_reset_out | soft_rst_q;

	// ==========================================================
	// Serial framing
	logic [7:0] sh_q, op_q, d1_q, d2_q, inb;
	logic [2:0] bit_q;
	logic [1:0] nb_q;
	assign inb = {sh_q[6:0], si_s};
	always_ff @(posedge clock_in or negedge por_n) begin
		if (!por_n) begin
			sh_q  <= 8'h00;
			op_q  <= 8'h00;
			d1_q  <= 8'h00;
			d2_q  <= 8'h00;
			bit_q <= 3'h0;
			nb_q  <= 2'h0;
		end else if (cs_n_s || sw_rst) begin
			bit_q <= 3'h0;
			nb_q  <= 2'h0;
		end else if (rise && !hold_out) begin
			sh_q  <= inb;
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				if (nb_q != 2'h3) nb_q <= nb_q + 2'h1;
				case (nb_q)
					2'h0: op_q <= inb;
					2'h1: d1_q <= inb;
					2'h2: d2_q <= inb;
					default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// Command decode, applied when chip select rises on a byte boundary
	logic exec, accept, is_rd, sp_open, wr_go, pe_op;
	assign exec   = cs_end && bit_q == 3'h0 && nb_q != 2'h0 && !sw_rst;
	assign is_rd  = op_q == `SFS_OP_RD1 || op_q == `SFS_OP_RD2 || op_q == `SFS_OP_RD3;
	assign accept = !busy_run || is_rd || op_q == `SFS_OP_SUSP; // [RULE2]
	// Pin protection only counts while the pin is not a data line
	assign sp_open = ({sp_high_q, sp_low_q} == 2'b00) || // [RULE8]
		({sp_high_q, sp_low_q} == 2'b01 && (wp_n_s || quad_enable_q)); // [RULE9] [RULE10] [RULE11]
	assign wr_go = exec && accept && sp_open && (write_enable_latch_q || vol_en_q) &&
		((op_q == `SFS_OP_WR1 && nb_q != 2'h1) || (op_q == `SFS_OP_WR2 && nb_q == 2'h2));
	assign pe_op = op_q == `SFS_OP_PP || op_q == `SFS_OP_QPP || op_q == `SFS_OP_SE ||
		op_q == `SFS_OP_BE32 || op_q == `SFS_OP_BE64 || op_q == `SFS_OP_CE ||
		op_q == `SFS_OP_CE2 || op_q == `SFS_OP_SSE || op_q == `SFS_OP_SSP ||
		op_q == `SFS_OP_WR1 || op_q == `SFS_OP_WR2;

	// Write-enable latch and volatile enable
	always_ff @(posedge clock_in or negedge por_n) begin
		if (!por_n) begin
			write_enable_latch_q <= 1'b0; // [RULE4]
			vol_en_q             <= 1'b0;
		end else if (sw_rst) begin
			write_enable_latch_q <= 1'b0;
			vol_en_q             <= 1'b0;
		end else if (exec && accept) begin
			if (op_q == `SFS_OP_WEN) write_enable_latch_q <= 1'b1; // [RULE3]
			else if (op_q == `SFS_OP_WDIS || pe_op) write_enable_latch_q <= 1'b0; // [RULE4]
			if (op_q == `SFS_OP_VWEN) vol_en_q <= 1'b1; // [RULE22]
			else vol_en_q <= 1'b0;
		end
	end

	// Configuration bits; power-on restores factory zeros, so 1,0 lock-down ends here
	always_ff @(posedge clock_in or negedge por_n) begin
		if (!por_n) begin
			{prot_q, bottom_q, sector_q, sp_low_q} <= 6'h00; // [RULE5] [RULE10]
			{sp_high_q, quad_enable_q, otp_lock_q, pin_mode_q} <= 4'h0;
			{drv_low_q, drv_high_q, invert_q, scheme_q} <= 4'h0;
		end else if (wr_go) begin
			if (op_q == `SFS_OP_WR1) begin
				{sp_low_q, sector_q, bottom_q, prot_q} <= d1_q[7:2]; // [RULE5] [RULE22]
			end
			if (op_q == `SFS_OP_WR2 || nb_q == 2'h3) begin
				sp_high_q  <= (op_q == `SFS_OP_WR2) ? d1_q[0] : d2_q[0];
				otp_lock_q <= otp_lock_q | ((op_q == `SFS_OP_WR2) ? d1_q[2] : d2_q[2]); // [RULE16]
				// QPI mode pins quad enable high
				quad_enable_q <= ((op_q == `SFS_OP_WR2) ? d1_q[1] : d2_q[1]) | qpi_q; // [RULE19]
				{scheme_q, invert_q, drv_high_q, drv_low_q, pin_mode_q} <=
					(op_q == `SFS_OP_WR2) ? d1_q[7:3] : d2_q[7:3]; // [RULE13] [RULE14]
			end
		end
	end

	// Busy timer of a non-volatile status write
	always_ff @(posedge clock_in or negedge por_n) begin
		if (!por_n) tw_q <= 16'h0;
		else if (sw_rst) tw_q <= 16'h0;
		else if (wr_go && !vol_en_q) tw_q <= 16'(TW_CYC); // [RULE1]
		else if (tw_q != 16'h0) tw_q <= tw_q - 16'h1;
	end

	// Event flags: a set in the clearing cycle wins
	always_ff @(posedge clock_in or negedge por_n) begin
		if (!por_n) begin
			err_q  <= 1'b0;
			susp_q <= 1'b0;
		end else begin
			err_q  <= eng_fail_in | (err_q & ~sw_rst & // [RULE23]
				~(exec && accept && op_q == `SFS_OP_WEN)); // [RULE20]
			susp_q <= (exec && op_q == `SFS_OP_SUSP) | // [RULE24]
				(susp_q & ~(exec && accept && op_q == `SFS_OP_RESUME));
		end
	end

	// QPI mode and two-step software reset
	always_ff @(posedge clock_in or negedge por_n) begin
		if (!por_n) begin
			qpi_q      <= 1'b0;
			arm_q      <= 1'b0;
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= exec && accept && arm_q && op_q == `SFS_OP_RST_GO;
			if (sw_rst) begin
				qpi_q <= 1'b0;
				arm_q <= 1'b0;
			end else if (exec && accept) begin
				arm_q <= op_q == `SFS_OP_RST_ARM;
				if (op_q == `SFS_OP_QPI_ON && quad_enable_q) qpi_q <= 1'b1; // [RULE18]
				else if (op_q == `SFS_OP_QPI_OFF) qpi_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Engine hand-off and configuration outputs
	always_ff @(posedge clock_in or negedge por_n) begin
		if (!por_n) begin
			cmd_valid_out   <= 1'b0;
			cmd_op_out      <= 8'h00;
			lock_preset_out <= 1'b1; // [RULE14]
			drive_pct_out   <= 7'd100;
		end else begin
			cmd_valid_out   <= exec && accept && !is_rd && op_q != `SFS_OP_WR1 &&
				op_q != `SFS_OP_WR2 && op_q != `SFS_OP_WEN && op_q != `SFS_OP_WDIS &&
				op_q != `SFS_OP_VWEN; // [RULE2]
			if (exec && accept) cmd_op_out <= op_q;
			lock_preset_out <= sw_rst; // [RULE14]
			case (sfs_drv_e'({drv_high_q, drv_low_q})) // [RULE15]
				SFS_DRV_100: drive_pct_out <= 7'd100;
				SFS_DRV_75:  drive_pct_out <= 7'd75;
				SFS_DRV_50:  drive_pct_out <= 7'd50;
				default:     drive_pct_out <= 7'd25;
			endcase
		end
	end
	assign qpi_mode_out    = qpi_q;
	assign prot_bits_out   = prot_q;
	assign prot_bottom_out = bottom_q; // [RULE6]
	assign prot_sector_out = sector_q; // [RULE7]
	assign prot_invert_out = invert_q; // [RULE13]
	assign prot_locks_out  = scheme_q; // [RULE14]
	assign secure_ro_out   = otp_lock_q; // [RULE16]

	// ==========================================================
	// Status read-out: live value, new bit after each falling serial edge
	logic [7:0] rd_byte;
	always_comb begin
		case (op_q)
			`SFS_OP_RD1: rd_byte = stat1; // [RULE21]
			`SFS_OP_RD2: rd_byte = stat2;
			default:     rd_byte = stat3;
		endcase
	end
	always_ff @(posedge clock_in or negedge por_n) begin
		if (!por_n) begin
			so_out    <= 1'b0;
			so_oe_out <= 1'b0;
		end else begin
			so_oe_out <= !cs_n_s && !hold_out && !sw_rst && is_rd && nb_q != 2'h0;
			if (fall) so_out <= rd_byte[3'h7 - bit_q]; // [RULE21]
		end
	end

	// ==========================================================
	// Checks
	sequence sr_commit_s;
		wr_go && !vol_en_q;
	endsequence
	sequence busy_hold_s;
		busy_out [*8];
	endsequence
	busy_tw_a: assert property (@(posedge clock_in) disable iff (!por_n || sw_rst) // [RULE1]
		sr_commit_s |=> busy_hold_s) else $error("busy not held after status write");
	busy_drop_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE2]
		exec && busy_run && op_q == `SFS_OP_WEN |=> !$rose(write_enable_latch_q))
		else $error("command taken while busy");
	latch_set_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE3]
		exec && accept && op_q == `SFS_OP_WEN |=> write_enable_latch_q)
		else $error("write enable did not set latch");
	latch_clear_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE4]
		exec && accept && (op_q == `SFS_OP_WDIS || pe_op) |=> !write_enable_latch_q)
		else $error("latch not cleared");
	hw_lock_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE9]
		exec && sp_low_q && !sp_high_q && !wp_n_s && !quad_enable_q |=> $stable(stat1[7:2]))
		else $error("write passed protect pin");
	down_lock_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE10]
		sp_high_q && !sp_low_q && exec |=> $stable(stat2) && $stable(stat1[7:2]))
		else $error("lock-down write passed");
	otp_lock_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE11]
		sp_high_q && sp_low_q |=> sp_high_q && sp_low_q && $stable(stat2))
		else $error("permanent lock changed");
	secure_otp_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE16]
		otp_lock_q |=> otp_lock_q) else $error("security lock cleared");
	qpi_gate_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE18]
		!quad_enable_q && !qpi_q |=> !qpi_q) else $error("QPI entered without quad");
	quad_keep_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE19]
		qpi_q |=> quad_enable_q) else $error("quad cleared in QPI");
	err_flag_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE23]
		eng_fail_in |=> err_q ##1 (err_q || $past(op_q) == `SFS_OP_WEN || $past(sw_rst)))
		else $error("write fail flag lost");
	susp_flag_a: assert property (@(posedge clock_in) disable iff (!por_n) // [RULE24]
		exec && op_q == `SFS_OP_SUSP |=> susp_q) else $error("suspend flag not set");
endmodule

// ==== tb/sfs_host_model.sv ====
// Purpose: Host controller model that frames commands on the serial pins
// Assumes: Serial clock period of 125 ns, mode 0, MSB first
// Notes:   Frames start 3 ns after a system clock edge so no pin moves on it
`timescale 1ns/100ps
module sfs_host_model (
	input  wire logic clock_in,
	input  wire logic so_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      si_out
);
	logic [7:0] rx;

	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
		rx = 8'h00;
	end

	// ==========================================================
	// One frame: opcode plus nb bytes; rx keeps the last byte read
	// ==========================================================
	task automatic frame(input logic [7:0] op, input int nb, input logic [15:0] wd);
		logic [23:0] sh;
		sh = {op, wd};
		repeat (10) @(posedge clock_in);
		#3;
		cs_n_out = 1'b0;
		for (int i = 0; i < 8 * (nb + 1); i++) begin
			si_out = sh[23 - i];
			#62.5 sclk_out = 1'b1;
			rx = {rx[6:0], so_in};
			#62.5 sclk_out = 1'b0;
		end
		#62.5 cs_n_out = 1'b1;
		// Released data line shows the inverse so a stale bit is never mistaken
		si_out = ~si_out;
	endtask
endmodule

// ==== tb/sfs_status_bank_test.sv ====
// Purpose: Self-checking bench for the flash status register bank
// Assumes: Status-write busy time shortened to 10 cycles
// Notes:   Non-volatile bits return to factory values on each rst_n_in pulse
`timescale 1ns/100ps
`include "sfs_consts.svh"
module sfs_status_bank_test import sfs_pkg::*;;
	logic       clock_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       wp_n_in = 1'b1;
	logic       hold_rst_n_in = 1'b1;
	logic       eng_busy_in = 1'b0;
	logic       eng_fail_in = 1'b0;
	logic       sclk, cs_n, si, so_out, so_oe_out, cmd_valid_out, busy_out, qpi_mode_out;
	logic       hold_out, pin_reset_out, prot_bottom_out, prot_sector_out;
	logic       prot_invert_out, prot_locks_out, lock_preset_out, secure_ro_out;
	logic [7:0] cmd_op_out, b1, b2, e1;
	logic [6:0] drive_pct_out;
	logic [2:0] prot_bits_out, bp;
	logic       bot_sel, inv_sel, lock_sel;
	int         num_errors = 0;
	int         oe_cycles = 0;
	int         checks = 0;
	int         pulses = 0;
	int         cycles = 0;
	int         p0;

	initial forever #5 clock_in = ~clock_in;

	sfs_status_bank #(.TW_CYC(10)) uut (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
		.si_in(si), .wp_n_in(wp_n_in), .hold_rst_n_in(hold_rst_n_in),
		.eng_busy_in(eng_busy_in), .eng_fail_in(eng_fail_in), .so_out(so_out),
		.so_oe_out(so_oe_out), .cmd_valid_out(cmd_valid_out), .cmd_op_out(cmd_op_out),
		.busy_out(busy_out), .qpi_mode_out(qpi_mode_out), .hold_out(hold_out),
		.pin_reset_out(pin_reset_out), .drive_pct_out(drive_pct_out),
		.prot_bits_out(prot_bits_out), .prot_bottom_out(prot_bottom_out),
		.prot_sector_out(prot_sector_out), .prot_invert_out(prot_invert_out),
		.prot_locks_out(prot_locks_out), .lock_preset_out(lock_preset_out),
		.secure_ro_out(secure_ro_out));

	sfs_host_model host (.clock_in(clock_in), .so_in(so_out), .sclk_out(sclk),
		.cs_n_out(cs_n), .si_out(si));

	always @(posedge clock_in) begin
		if (cmd_valid_out === 1'b1) pulses <= pulses + 1;
		if (so_oe_out === 1'b1) oe_cycles <= oe_cycles + 1;
		cycles <= cycles + 1;
		// Whole run needs about 19k cycles
		if (cycles == 90000) begin
			num_errors++;
			results();
		end
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic [7:0] pct(input logic hi, input logic lo);
		case ({hi, lo})
			2'b00: return 8'h64;
			2'b10: return 8'h4b;
			2'b01: return 8'h32;
			default: return 8'h19;
		endcase
	endfunction

	task automatic results();
		if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic do_reset();
		@(posedge clock_in);
		rst_n_in <= 1'b0;
		repeat (8) @(posedge clock_in);
		rst_n_in <= 1'b1;
		repeat (10) @(posedge clock_in);
	endtask

	task automatic cmd(input logic [7:0] op);
		host.frame(op, 0, 16'h0000);
		repeat (6) @(posedge clock_in);
	endtask

	task automatic rchk(input logic [7:0] op, input string nm, input logic [7:0] exp);
		int o0;
		o0 = oe_cycles;
		host.frame(op, 1, 16'h0000);
		repeat (6) @(posedge clock_in);
		chk(nm, exp, host.rx);
		// Drive enable must have been up during the read and be down once deselected
		chk("read drive enable", 8'h02, {6'h00, oe_cycles != o0, so_oe_out});
	endtask

	// A taken status write shows as busy at least once within 40 cycles
	task automatic wr(input logic [7:0] op, input int nb, input logic [15:0] d, input logic ok);
		logic saw;
		saw = 1'b0;
		if (op == `SFS_OP_WR1 || op == `SFS_OP_WR2) cmd(`SFS_OP_WEN);
		host.frame(op, nb, d);
		repeat (40) @(posedge clock_in) if (busy_out === 1'b1) saw = 1'b1;
		chk("status write taken", {7'h00, ok}, {7'h00, saw});
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		void'($urandom(84));
		do_reset();
		rchk(`SFS_OP_RD1, "status1 factory", 8'h00);
		rchk(`SFS_OP_RD2, "status2 factory", 8'h00);
		rchk(`SFS_OP_RD3, "status3 factory", 8'h00);
		chk("drive factory", 8'h64, {1'b0, drive_pct_out});
		cmd(`SFS_OP_WEN);
		rchk(`SFS_OP_RD1, "latch set", 8'h02);
		cmd(`SFS_OP_WDIS);
		rchk(`SFS_OP_RD1, "latch cleared", 8'h00);
		host.frame(`SFS_OP_WR1, 2, 16'h1c00);
		repeat (40) @(posedge clock_in);
		rchk(`SFS_OP_RD1, "write without latch", 8'h00);
		for (int k = 0; k < 4; k++) begin
			bp = 3'($urandom);
			{bot_sel, inv_sel, lock_sel} = 3'($urandom);
			b1 = {1'b0, 1'b0, bot_sel, bp, 2'b00};
			b2 = {lock_sel, inv_sel, k[1], k[0], 4'h0};
			wr(`SFS_OP_WR1, 2, {b1, b2}, 1'b1);
			rchk(`SFS_OP_RD1, "status1 written", b1);
			rchk(`SFS_OP_RD2, "status2 written", b2);
			chk("protect fields", {1'b0, 1'b0, bp, bot_sel, inv_sel, lock_sel},
				{1'b0, prot_sector_out, prot_bits_out, prot_bottom_out,
				prot_invert_out, prot_locks_out});
			chk("drive", pct(k[1], k[0]), {1'b0, drive_pct_out});
			e1 = b1;
		end
		wr(`SFS_OP_WR2, 1, 16'h0000, 1'b1);
		rchk(`SFS_OP_RD2, "status2 via 31h", 8'h00);
		cmd(`SFS_OP_VWEN);
		host.frame(`SFS_OP_WR2, 1, 16'h2000);
		repeat (6) @(posedge clock_in);
		rchk(`SFS_OP_RD2, "volatile write", 8'h20);
		chk("drive volatile", pct(1'b1, 1'b0), {1'b0, drive_pct_out});
		@(posedge clock_in);
		eng_busy_in <= 1'b1;
		p0 = pulses;
		cmd(`SFS_OP_WEN);
		cmd(`SFS_OP_PP);
		rchk(`SFS_OP_RD1, "busy read", e1 | 8'h01);
		chk("no pulse while busy", 8'h00, 8'(pulses - p0));
		eng_busy_in <= 1'b0;
		p0 = pulses;
		for (int i = 0; i < 9; i++) begin
			b2 = (i == 0) ? `SFS_OP_PP : (i == 1) ? `SFS_OP_QPP : (i == 2) ? `SFS_OP_SE :
				(i == 3) ? `SFS_OP_BE32 : (i == 4) ? `SFS_OP_BE64 : (i == 5) ? `SFS_OP_CE :
				(i == 6) ? `SFS_OP_CE2 : (i == 7) ? `SFS_OP_SSE : `SFS_OP_SSP;
			cmd(`SFS_OP_WEN);
			cmd(b2);
			chk("forwarded op", b2, cmd_op_out);
			rchk(`SFS_OP_RD1, "latch after op", e1);
		end
		chk("pulses forwarded", 8'h09, 8'(pulses - p0));
		@(posedge clock_in);
		eng_fail_in <= 1'b1;
		@(posedge clock_in);
		eng_fail_in <= 1'b0;
		rchk(`SFS_OP_RD3, "write fail set", 8'h04);
		cmd(`SFS_OP_WEN);
		rchk(`SFS_OP_RD3, "write fail cleared", 8'h00);
		@(posedge clock_in);
		eng_fail_in <= 1'b1;
		@(posedge clock_in);
		eng_fail_in <= 1'b0;
		cmd(`SFS_OP_RST_ARM);
		cmd(`SFS_OP_RST_GO);
		rchk(`SFS_OP_RD3, "write fail after soft reset", 8'h00);
		cmd(`SFS_OP_SUSP);
		rchk(`SFS_OP_RD3, "suspend set", 8'h80);
		cmd(`SFS_OP_RESUME);
		rchk(`SFS_OP_RD3, "suspend cleared", 8'h00);
		wr(`SFS_OP_WR1, 2, 16'h8000, 1'b1);
		@(posedge clock_in);
		wp_n_in <= 1'b0;
		wr(`SFS_OP_WR1, 2, 16'h8020, 1'b0);
		@(posedge clock_in);
		wp_n_in <= 1'b1;
		wr(`SFS_OP_WR1, 2, 16'h0001, 1'b1);
		wr(`SFS_OP_WR1, 2, 16'h0000, 1'b0);
		rchk(`SFS_OP_RD2, "lock-down kept", 8'h01);
		do_reset();
		rchk(`SFS_OP_RD2, "lock-down released", 8'h00);
		wr(`SFS_OP_WR1, 2, 16'h8001, 1'b1);
		wr(`SFS_OP_WR2, 1, 16'h0000, 1'b0);
		do_reset();
		cmd(`SFS_OP_QPI_ON);
		chk("qpi refused", 8'h00, {7'h00, qpi_mode_out});
		wr(`SFS_OP_WR2, 1, 16'h0a00, 1'b1);
		@(posedge clock_in);
		hold_rst_n_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk("pin reset off in quad", 8'h00, {7'h00, pin_reset_out});
		hold_rst_n_in <= 1'b1;
		cmd(`SFS_OP_QPI_ON);
		chk("qpi entered", 8'h01, {7'h00, qpi_mode_out});
		wr(`SFS_OP_WR2, 1, 16'h0800, 1'b1);
		rchk(`SFS_OP_RD2, "quad kept in qpi", 8'h0a);
		cmd(`SFS_OP_QPI_OFF);
		wr(`SFS_OP_WR2, 1, 16'h0800, 1'b1);
		@(posedge clock_in);
		hold_rst_n_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk("pin reset active", 8'h01, {7'h00, pin_reset_out});
		chk("lock preset on pin reset", 8'h01, {7'h00, lock_preset_out});
		hold_rst_n_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		rchk(`SFS_OP_RD2, "config after pin reset", 8'h08);
		wr(`SFS_OP_WR2, 1, 16'h0400, 1'b1);
		chk("security read-only", 8'h01, {7'h00, secure_ro_out});
		wr(`SFS_OP_WR2, 1, 16'h0000, 1'b1);
		rchk(`SFS_OP_RD2, "lock bit kept", 8'h04);
		// Hold pin pulled low in the middle of a selected frame
		fork
			host.frame(`SFS_OP_RD2, 1, 16'h0000);
			begin
				repeat (30) @(posedge clock_in);
				hold_rst_n_in <= 1'b0;
				repeat (4) @(posedge clock_in);
				chk("hold active", 8'h01, {7'h00, hold_out});
				hold_rst_n_in <= 1'b1;
			end
		join
		repeat (6) @(posedge clock_in);
		results();
	end
endmodule
